// [tpc_pkg.sv]
// constants, field layouts and types of the 16-bit timer with pwm and capture
// assumes one 20 MHz clock and an ahb-lite register bus with 32-bit data
package tpc_pkg;
    // ==========================================================
    // widths
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int PRE_W = 10;
    localparam int EV_W = 3;
    // ==========================================================
    // register indices, byte address is index times four
    localparam logic [7:0] IDX_CONTROL = 8'hC2;
    localparam logic [7:0] IDX_IRQ_FLAGS = 8'hC3;
    localparam logic [7:0] IDX_COUNT_LOW = 8'hC4;
    localparam logic [7:0] IDX_COUNT_HIGH = 8'hC5;
    localparam logic [7:0] IDX_COMPARE_LOW = 8'hC6;
    localparam logic [7:0] IDX_COMPARE_HIGH = 8'hC7;
    localparam logic [7:0] IDX_CAPTURE_CFG = 8'hC8;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hC9;
    localparam logic [7:0] IDX_IRQ_CLEAR = 8'hCA;
    localparam logic [7:0] IDX_IRQ_ENABLE = 8'hCB;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 9;
    // ==========================================================
    // field positions
    localparam int CTL_EN_BIT = 7;
    localparam int CTL_OE_BIT = 6;
    localparam int CTL_MODE_MSB = 5;
    localparam int CTL_MODE_LSB = 4;
    localparam int CTL_CLK_MSB = 3;
    localparam int CTL_CLK_LSB = 1;
    localparam int CTL_CLEAR_BIT = 0;
    localparam int FLAG_OVF_BIT = 5;
    localparam int FLAG_MATCH_BIT = 3;
    localparam int CFG_EDGE_BIT = 0;
    localparam int CFG_POL_BIT = 1;
    localparam int EV_MATCH = 0;
    localparam int EV_OVF = 1;
    localparam int EV_CAP = 2;
    // ==========================================================
    // reset values and limits
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_COMPARE_BYTE = 8'hFF;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] RST_CAPTURE = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [1:0] RST_CFG = 2'h0;
    localparam logic [2:0] RST_EV = 3'h0;
    localparam logic [31:0] RD_ZERO = 32'h00000000;
    localparam logic HRESP_OKAY = 1'b0;
    // ==========================================================
    // types
    typedef enum logic [1:0] {
        TPC_MODE_TIMER = 2'b00,
        TPC_MODE_PWM = 2'b01,
        TPC_MODE_CAPTURE = 2'b10,
        TPC_MODE_CAPTURE_ALT = 2'b11
    } tpc_mode_t;
    typedef enum logic [2:0] {
        TPC_CLK_DIV1 = 3'b000,
        TPC_CLK_DIV2 = 3'b001,
        TPC_CLK_DIV16 = 3'b010,
        TPC_CLK_DIV64 = 3'b011,
        TPC_CLK_DIV256 = 3'b100,
        TPC_CLK_DIV512 = 3'b101,
        TPC_CLK_DIV1024 = 3'b110,
        TPC_CLK_EXT = 3'b111
    } tpc_clk_sel_t;
    // prescaler masks, tick when the masked count is all ones
    localparam logic [9:0] MASK_DIV1 = 10'h000;
    localparam logic [9:0] MASK_DIV2 = 10'h001;
    localparam logic [9:0] MASK_DIV16 = 10'h00F;
    localparam logic [9:0] MASK_DIV64 = 10'h03F;
    localparam logic [9:0] MASK_DIV256 = 10'h0FF;
    localparam logic [9:0] MASK_DIV512 = 10'h1FF;
    localparam logic [9:0] MASK_DIV1024 = 10'h3FF;
endpackage

// [tpc_prescaler.sv]
// count clock source for the timer: divider chain or external edge
// assumes ext_rise is already synchronised, one cycle wide
`timescale 1ns/1ns
module tpc_prescaler (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // control
    input wire logic run,
    input wire logic [2:0] clk_sel,
    input wire logic ext_rise,
    // result
    output logic tick
);
    import tpc_pkg::*;
    logic [PRE_W-1:0] pre;
    logic [PRE_W-1:0] next_pre;
    logic [PRE_W-1:0] mask;

    // ==========================================================
    // divider chain
    always_comb begin
        next_pre = run ? PRE_W'(pre + 1'b1) : '0;
        mask = MASK_DIV1;
        case (tpc_clk_sel_t'(clk_sel))
            TPC_CLK_DIV1: mask = MASK_DIV1;
            TPC_CLK_DIV2: mask = MASK_DIV2;
            TPC_CLK_DIV16: mask = MASK_DIV16;
            TPC_CLK_DIV64: mask = MASK_DIV64;
            TPC_CLK_DIV256: mask = MASK_DIV256;
            TPC_CLK_DIV512: mask = MASK_DIV512;
            TPC_CLK_DIV1024: mask = MASK_DIV1024;
            default: mask = MASK_DIV1;
        endcase
        if (tpc_clk_sel_t'(clk_sel) == TPC_CLK_EXT) begin
            tick = run & ext_rise;
        end else begin
            tick = run & ((pre & mask) == mask);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pre <= '0;
        end else begin
            pre <= next_pre;
        end
    end
endmodule

// [tpc_timer.sv]
// 16-bit timer with compare output, pwm and input capture, ahb-lite slave
// assumes pins come from outside the clock domain, irq_ack from same clock
`timescale 1ns/1ns
module tpc_timer (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [tpc_pkg::DATA_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [tpc_pkg::DATA_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [tpc_pkg::DATA_W-1:0] hrdata,
    // pins
    input wire logic external_clock_pin,
    input wire logic capture_trigger_input,
    output logic timer_output_pin,
    // interrupt controller
    input wire logic irq_ack,
    output logic irq
);
    import tpc_pkg::*;

    // ==========================================================
    // state
    logic dp_valid;
    logic dp_write;
    logic dp_hit;
    logic [7:0] dp_idx;
    logic [7:0] control;
    logic [15:0] compare;
    logic [15:0] count;
    logic [15:0] captured;
    logic flag_match;
    logic flag_ovf;
    logic [1:0] cap_cfg;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] irq_en;
    logic out_toggle;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic trg_s1;
    logic trg_s2;
    logic trg_prev;
    logic next_dp_valid;
    logic next_dp_write;
    logic next_dp_hit;
    logic [7:0] next_dp_idx;
    logic [DATA_W-1:0] next_hrdata;
    logic [7:0] next_control;
    logic [15:0] next_compare;
    logic [15:0] next_count;
    logic [15:0] next_captured;
    logic next_flag_match;
    logic next_flag_ovf;
    logic [1:0] next_cap_cfg;
    logic [EV_W-1:0] next_status;
    logic [EV_W-1:0] next_irq_en;
    logic next_out_toggle;
    logic next_pin;
    logic next_irq;
    logic next_trg_prev;

    // ==========================================================
    // decoded terms
    logic enabled;
    logic out_en;
    logic is_pwm;
    logic is_cap;
    logic tick;
    logic ext_rise;
    logic at_match;
    logic ev_match;
    logic ev_ovf;
    logic ev_cap;
    logic trg_active;
    logic wr;
    logic [7:0] wbyte;
    logic clear_wr;
    logic ap_take;
    logic ap_hit;
    logic [7:0] ap_idx;
    logic [DATA_W-1:0] rd_val;
    logic [EV_W-1:0] ev_vec;

    assign enabled = control[CTL_EN_BIT];
    assign out_en = control[CTL_OE_BIT];
    assign is_pwm = tpc_mode_t'(control[CTL_MODE_MSB:CTL_MODE_LSB]) == TPC_MODE_PWM;
    assign is_cap = control[CTL_MODE_MSB];
    assign ext_rise = ext_s2 & ~ext_s3;
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;

    // ==========================================================
    // count clock source
    tpc_prescaler u_prescaler (
        .clock(clock),
        .rst_n(rst_n),
        .run(enabled),
        .clk_sel(control[CTL_CLK_MSB:CTL_CLK_LSB]),
        .ext_rise(ext_rise),
        .tick(tick)
    );

    // ==========================================================
    // next-state logic
    always_comb begin
        // bus address phase
        ap_take = hsel & htrans[1] & hready;
        ap_idx = haddr[IDX_MSB:IDX_LSB];
        ap_hit = (haddr[DATA_W-1:IDX_MSB+1] == '0) & (haddr[IDX_LSB-1:0] == '0);
        next_dp_valid = ap_take;
        next_dp_write = hwrite;
        next_dp_hit = ap_hit;
        next_dp_idx = ap_idx;
        wr = dp_valid & dp_write & dp_hit;
        wbyte = hwdata[7:0];
        clear_wr = wr & (dp_idx == IDX_CONTROL) & wbyte[CTL_CLEAR_BIT];

        // read mux, unmapped reads give zero
        rd_val = RD_ZERO;
        if (!ap_hit) begin
            rd_val = RD_ZERO;
        end else if (ap_idx == IDX_CONTROL) begin
            rd_val[7:0] = control;
        end else if (ap_idx == IDX_IRQ_FLAGS) begin
            rd_val[FLAG_MATCH_BIT] = flag_match;
            rd_val[FLAG_OVF_BIT] = flag_ovf;
        end else if (ap_idx == IDX_COUNT_LOW) begin
            rd_val[7:0] = count[7:0];
        end else if (ap_idx == IDX_COUNT_HIGH) begin
            rd_val[7:0] = count[15:8];
        end else if (ap_idx == IDX_COMPARE_LOW) begin
            rd_val[7:0] = is_cap ? captured[7:0] : compare[7:0];
        end else if (ap_idx == IDX_COMPARE_HIGH) begin
            rd_val[7:0] = is_cap ? captured[15:8] : compare[15:8];
        end else if (ap_idx == IDX_CAPTURE_CFG) begin
            rd_val[1:0] = cap_cfg;
        end else if (ap_idx == IDX_IRQ_STATUS) begin
            rd_val[EV_W-1:0] = status;
        end else if (ap_idx == IDX_IRQ_ENABLE) begin
            rd_val[EV_W-1:0] = irq_en;
        end
        next_hrdata = (ap_take & ~hwrite) ? rd_val : RD_ZERO;

        // register writes, clear bit never stored
        next_control = control;
        next_compare = compare;
        next_cap_cfg = cap_cfg;
        next_irq_en = irq_en;
        if (wr & (dp_idx == IDX_CONTROL)) begin
            next_control = wbyte;
            next_control[CTL_CLEAR_BIT] = 1'b0;
        end
        if (wr & (dp_idx == IDX_COMPARE_LOW)) begin
            next_compare[7:0] = wbyte;
        end
        if (wr & (dp_idx == IDX_COMPARE_HIGH)) begin
            next_compare[15:8] = wbyte;
        end
        if (wr & (dp_idx == IDX_CAPTURE_CFG)) begin
            next_cap_cfg = wbyte[1:0];
        end
        if (wr & (dp_idx == IDX_IRQ_ENABLE)) begin
            next_irq_en = wbyte[EV_W-1:0];
        end

        // counter
        at_match = count == compare;
        ev_match = enabled & tick & at_match;
        ev_ovf = enabled & tick & is_pwm & (count == CNT_MAX);
        next_count = count;
        if (enabled & tick) begin
            if (!is_pwm & at_match) begin
                next_count = RST_COUNT;
            end else begin
                next_count = CNT_W'(count + 1'b1);
            end
        end
        if (clear_wr) begin
            next_count = RST_COUNT;
        end

        // capture trigger, level or edge of chosen polarity
        trg_active = cap_cfg[CFG_POL_BIT] ? trg_s2 : ~trg_s2;
        next_trg_prev = trg_active;
        if (cap_cfg[CFG_EDGE_BIT]) begin
            ev_cap = enabled & is_cap & trg_active & ~trg_prev;
        end else begin
            ev_cap = enabled & is_cap & trg_active;
        end
        next_captured = ev_cap ? count : captured;

        // output pin
        next_out_toggle = out_toggle;
        if (!enabled) begin
            next_out_toggle = 1'b0;
        end else if (ev_match) begin
            next_out_toggle = ~out_toggle;
        end
        next_pin = 1'b0;
        if (enabled & out_en & !is_cap) begin
            if (is_pwm) begin
                next_pin = count < compare;
            end else begin
                next_pin = out_toggle;
            end
        end

        // flags, set wins over any clear
        next_flag_match = flag_match;
        next_flag_ovf = flag_ovf;
        if (irq_ack) begin
            next_flag_match = 1'b0;
            next_flag_ovf = 1'b0;
        end
        if (wr & (dp_idx == IDX_IRQ_FLAGS)) begin
            if (!wbyte[FLAG_MATCH_BIT]) begin
                next_flag_match = 1'b0;
            end
            if (!wbyte[FLAG_OVF_BIT]) begin
                next_flag_ovf = 1'b0;
            end
        end
        if (ev_match) begin
            next_flag_match = 1'b1;
        end
        if (ev_ovf) begin
            next_flag_ovf = 1'b1;
        end

        // sticky status, write-one clear, masked level
        ev_vec = RST_EV;
        ev_vec[EV_MATCH] = ev_match;
        ev_vec[EV_OVF] = ev_ovf;
        ev_vec[EV_CAP] = ev_cap;
        next_status = status;
        if (wr & (dp_idx == IDX_IRQ_CLEAR)) begin
            next_status = status & ~wbyte[EV_W-1:0];
        end
        next_status = next_status | ev_vec;
        next_irq = |(next_status & next_irq_en);
    end

    // ==========================================================
    // registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dp_valid <= 1'b0;
            dp_write <= 1'b0;
            dp_hit <= 1'b0;
            dp_idx <= '0;
            hrdata <= RD_ZERO;
            control <= RST_CONTROL;
            compare <= {RST_COMPARE_BYTE, RST_COMPARE_BYTE};
            count <= RST_COUNT;
            captured <= RST_CAPTURE;
            flag_match <= 1'b0;
            flag_ovf <= 1'b0;
            cap_cfg <= RST_CFG;
            status <= RST_EV;
            irq_en <= RST_EV;
            out_toggle <= 1'b0;
            timer_output_pin <= 1'b0;
            irq <= 1'b0;
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
            trg_s1 <= 1'b0;
            trg_s2 <= 1'b0;
            trg_prev <= 1'b0;
        end else begin
            dp_valid <= next_dp_valid;
            dp_write <= next_dp_write;
            dp_hit <= next_dp_hit;
            dp_idx <= next_dp_idx;
            hrdata <= next_hrdata;
            control <= next_control;
            compare <= next_compare;
            count <= next_count;
            captured <= next_captured;
            flag_match <= next_flag_match;
            flag_ovf <= next_flag_ovf;
            cap_cfg <= next_cap_cfg;
            status <= next_status;
            irq_en <= next_irq_en;
            out_toggle <= next_out_toggle;
            timer_output_pin <= next_pin;
            irq <= next_irq;
            ext_s1 <= external_clock_pin;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
            trg_s1 <= capture_trigger_input;
            trg_s2 <= trg_s1;
            trg_prev <= next_trg_prev;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    chk_match_clears: assert property (
        enabled && tick && !is_pwm && at_match && !clear_wr |=> count == RST_COUNT && flag_match
    ) else $error("match did not clear the counter");

    chk_pwm_keeps: assert property (
        enabled && tick && is_pwm && at_match && count != CNT_MAX && !clear_wr
        |=> count == $past(count) + 16'h0001 && flag_match
    ) else $error("pwm match disturbed the counter");

    chk_pwm_wrap: assert property (
        enabled && tick && is_pwm && count == CNT_MAX && !clear_wr
        |=> count == RST_COUNT && flag_ovf && status[EV_OVF]
    ) else $error("pwm wrap lost or no overflow flag");

    chk_clear_write: assert property (
        clear_wr |=> count == RST_COUNT && !control[CTL_CLEAR_BIT]
    ) else $error("clear bit did not clear the counter");

    chk_capture_load: assert property (
        ev_cap |=> captured == $past(count) && status[EV_CAP]
    ) else $error("capture value wrong");

    chk_capture_read: assert property (
        hsel && htrans[1] && hready && !hwrite && is_cap && haddr == {22'h0, IDX_COMPARE_LOW, 2'h0}
        |=> hrdata[7:0] == $past(captured[7:0])
    ) else $error("capture mode read did not give capture value");

    chk_flag_set_wins: assert property (
        ev_match && irq_ack |=> flag_match
    ) else $error("match flag lost to a clear");

    chk_pin_off_capture: assert property (
        is_cap ##1 is_cap |-> !timer_output_pin
    ) else $error("output pin driven in capture mode");

    chk_idle_holds: assert property (
        enabled && !tick && !clear_wr |=> count == $past(count)
    ) else $error("counter moved without a tick");
endmodule

// [tpc_pin_model.sv]
// far-side pin model: external count clock and capture trigger
// assumes the bench calls its tasks right after a rising clock edge
`timescale 1ns/1ns
module tpc_pin_model (
    // clock
    input wire logic clock,
    // pins toward the timer
    output logic ext_clk,
    output logic trig
);
    // ==========================================================
    // idle levels, both pins rest low between events
    initial begin
        ext_clk = 1'b0;
        trig = 1'b0;
    end
    // ==========================================================
    // n full pulses, each wide enough for the input synchroniser
    task automatic ext_edges(input int n);
        repeat (n) begin
            ext_clk <= 1'b1;
            repeat (4) @(posedge clock);
            ext_clk <= 1'b0;
            repeat (4) @(posedge clock);
        end
    endtask
    // ==========================================================
    // one rising trigger pulse
    task automatic trig_pulse();
        trig <= 1'b1;
        repeat (4) @(posedge clock);
        trig <= 1'b0;
        repeat (4) @(posedge clock);
    endtask
endmodule

// [tb_tpc_timer.sv]
// self-checking bench of the 16-bit timer through its register bus
// assumes tpc_pkg and tpc_pin_model are compiled before it
`timescale 1ns/1ns
module tb_tpc_timer;
    import tpc_pkg::*;
    logic clock, rst_n, hsel, hwrite, irq_ack, hreadyout, hresp;
    logic timer_output_pin, irq, ext_clk, trig;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int n_fail, cmp_count, cnt, cnt2, k;
    int divs[7] = '{1, 2, 16, 64, 256, 512, 1024};
    // ==========================================================
    // design and pin model
    tpc_timer tpc_timer_inst (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .external_clock_pin(ext_clk), .capture_trigger_input(trig),
        .timer_output_pin(timer_output_pin), .irq_ack(irq_ack), .irq(irq));
    tpc_pin_model tpc_pin_model_inst (.clock(clock), .ext_clk(ext_clk), .trig(trig));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    // ==========================================================
    // report and compare helpers
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic fail_msg(input string m);
        n_fail++;
        $display("FAIL %0t %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge clock);
    endtask
    // ==========================================================
    // ahb-lite single word transfer
    task automatic wait_rdy();
        int w;
        w = 0;
        @(posedge clock);
        while (hreadyout !== 1'b1) begin
            w++;
            if (w > 50) begin
                fail_msg("bus hang");
                close_out();
            end
            @(posedge clock);
        end
    endtask
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        if (hresp !== HRESP_OKAY) fail_msg("error response");
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, {24'h0, d});
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input string m);
        xfer(1'b0, idx, 32'h0);
        chk(rd, {24'h0, exp}, m);
    endtask
    task automatic rd_count(output int c);
        xfer(1'b0, IDX_COUNT_LOW, 32'h0);
        c = int'(rd[7:0]);
        xfer(1'b0, IDX_COUNT_HIGH, 32'h0);
        c = c + 256 * int'(rd[7:0]);
    endtask
    // ==========================================================
    // main sequence
    initial begin
        n_fail = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        irq_ack = 1'b0;
        ticks(6);
        rst_n <= 1'b1;
        ticks(1);
        // reset values, read-only and unmapped places
        rdc(IDX_CONTROL, 8'h00, "control reset");
        rdc(IDX_IRQ_FLAGS, 8'h00, "flags reset");
        rdc(IDX_COUNT_LOW, 8'h00, "count low reset");
        rdc(IDX_COUNT_HIGH, 8'h00, "count high reset");
        rdc(IDX_COMPARE_LOW, 8'hFF, "compare low reset");
        rdc(IDX_COMPARE_HIGH, 8'hFF, "compare high reset");
        rdc(IDX_IRQ_STATUS, 8'h00, "status reset");
        wr(8'hD0, 8'hAA);
        rdc(8'hD0, 8'h00, "unmapped read");
        wr(IDX_COUNT_LOW, 8'h5A);
        rdc(IDX_COUNT_LOW, 8'h00, "count is read only");
        // every divider, counted over a fixed window
        for (int i = 0; i < 7; i++) begin
            wr(IDX_CONTROL, 8'h01);
            rdc(IDX_CONTROL, 8'h00, "clear bit reads 0");
            rdc(IDX_COUNT_LOW, 8'h00, "counter cleared");
            wr(IDX_CONTROL, {1'b1, 3'b000, 3'(i), 1'b0});
            ticks(2048);
            wr(IDX_CONTROL, 8'h00);
            rd_count(cnt);
            cmp_count++;
            if (cnt < 2048 / divs[i] - 1 || cnt > 2048 / divs[i] + 4) fail_msg("divider rate");
        end
        // timer mode on the external clock, match, output, interrupts
        wr(IDX_COMPARE_LOW, 8'h03);
        wr(IDX_COMPARE_HIGH, 8'h00);
        wr(IDX_IRQ_ENABLE, 8'h01);
        wr(IDX_CONTROL, 8'hCF);
        rdc(IDX_CONTROL, 8'hCE, "control readback");
        tpc_pin_model_inst.ext_edges(5);
        ticks(6);
        rdc(IDX_COUNT_LOW, 8'h01, "count after match");
        rdc(IDX_IRQ_FLAGS, 8'h08, "match flag");
        rdc(IDX_IRQ_STATUS, 8'h01, "match status");
        chk({31'h0, timer_output_pin}, 32'h1, "pin toggled on match");
        chk({31'h0, irq}, 32'h1, "irq raised");
        wr(IDX_IRQ_ENABLE, 8'h00);
        ticks(2);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(IDX_IRQ_ENABLE, 8'h01);
        ticks(2);
        chk({31'h0, irq}, 32'h1, "irq unmasked");
        wr(IDX_IRQ_CLEAR, 8'h01);
        ticks(2);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        rdc(IDX_IRQ_STATUS, 8'h00, "status cleared");
        wr(IDX_IRQ_FLAGS, 8'h08);
        rdc(IDX_IRQ_FLAGS, 8'h08, "write 1 keeps flag");
        wr(IDX_IRQ_FLAGS, 8'h00);
        rdc(IDX_IRQ_FLAGS, 8'h00, "write 0 clears flag");
        tpc_pin_model_inst.ext_edges(3);
        ticks(6);
        rdc(IDX_IRQ_FLAGS, 8'h08, "second match");
        chk({31'h0, timer_output_pin}, 32'h0, "pin toggled back");
        irq_ack <= 1'b1;
        ticks(1);
        irq_ack <= 1'b0;
        rdc(IDX_IRQ_FLAGS, 8'h00, "ack clears flag");
        // fast matches while ack is held, the last match lands on an ack edge
        wr(IDX_CONTROL, 8'hC1);
        irq_ack <= 1'b1;
        ticks(8);
        irq_ack <= 1'b0;
        wr(IDX_CONTROL, 8'h00);
        rdc(IDX_IRQ_FLAGS, 8'h08, "match set beats ack");
        // capture in both capture codes, shared addresses
        wr(IDX_COMPARE_LOW, 8'hFF);
        wr(IDX_COMPARE_HIGH, 8'hFF);
        wr(IDX_IRQ_CLEAR, 8'h07);
        for (int m = 2; m < 4; m++) begin
            // rising edge trigger first, then low level trigger
            wr(IDX_CAPTURE_CFG, (m == 2) ? 8'h03 : 8'h00);
            wr(IDX_CONTROL, {2'b11, 2'(m), 4'hF});
            tpc_pin_model_inst.ext_edges(6);
            ticks(6);
            tpc_pin_model_inst.trig_pulse();
            ticks(6);
            rdc(IDX_COMPARE_LOW, 8'h06, "captured low");
            rdc(IDX_COMPARE_HIGH, 8'h00, "captured high");
            wr(IDX_COMPARE_LOW, 8'h55);
            rdc(IDX_COMPARE_LOW, 8'h06, "capture still read");
            rdc(IDX_IRQ_STATUS, 8'h04, "capture status");
            chk({31'h0, timer_output_pin}, 32'h0, "pin off in capture");
            wr(IDX_IRQ_CLEAR, 8'h07);
        end
        wr(IDX_CONTROL, 8'h00);
        rdc(IDX_COMPARE_LOW, 8'h55, "compare took write");
        // pwm: match keeps counting, wrap and overflow
        wr(IDX_COMPARE_LOW, 8'h10);
        wr(IDX_COMPARE_HIGH, 8'h00);
        wr(IDX_IRQ_FLAGS, 8'h00);
        wr(IDX_CONTROL, 8'hD1);
        ticks(40);
        rd_count(cnt);
        cmp_count++;
        if (cnt <= 16) fail_msg("pwm match cleared counter");
        rdc(IDX_IRQ_FLAGS, 8'h08, "pwm match flag");
        chk({31'h0, timer_output_pin}, 32'h0, "pwm low past compare");
        wr(IDX_COMPARE_LOW, 8'hFF);
        ticks(2);
        chk({31'h0, timer_output_pin}, 32'h1, "pwm high below compare");
        k = 0;
        rd = 32'h0;
        while (rd[FLAG_OVF_BIT] !== 1'b1) begin
            k++;
            if (k > 1200) begin
                fail_msg("no overflow");
                close_out();
            end
            ticks(64);
            xfer(1'b0, IDX_IRQ_FLAGS, 32'h0);
        end
        rdc(IDX_IRQ_FLAGS, 8'h28, "overflow flag");
        rdc(IDX_COUNT_HIGH, 8'h00, "count wrapped");
        rd_count(cnt);
        rd_count(cnt2);
        chk({31'h0, cnt2 > cnt}, 32'h1, "count runs on");
        close_out();
    end
endmodule
